// *** channel_transfer_mode_port.sv ***
`timescale 1ns/1ps
module channel_transfer_mode_port
	import chan_port_pkg::*;
#(
	parameter logic [7:0] UNIT_ADDR = 8'h00
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire chan_port_pkg::xfer_mode_t mode_i,
	input wire logic accel_i,
	input wire chan_port_pkg::bus_byte_t bus_out_i,
	input wire logic address_out_i,
	input wire logic command_out_i,
	input wire logic service_out_i,
	input wire logic data_out_i,
	input wire logic operational_out_i,
	input wire logic hold_out_i,
	input wire logic select_out_i,
	input wire logic suppress_out_i,
	output chan_port_pkg::bus_byte_t bus_in_o,
	output logic address_in_o,
	output logic status_in_o,
	output logic service_in_o,
	output logic data_in_o,
	output logic disconnect_in_o,
	output logic operational_in_o,
	output logic select_in_o,
	output logic request_in_o,
	output logic mark0_in_o,
	input wire logic retry_req_i,
	output logic [7:0] drive_cmd_o,
	output logic drive_cmd_valid_o,
	input wire logic drive_done_i,
	input wire logic rd_valid_i,
	output logic rd_ready_o,
	input wire logic [7:0] rd_data_i,
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic [7:0] wr_data_o,
	output logic parity_err_o
);
	import chan_port_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Channel pins are asynchronous to mclk_i
	localparam int NSYNC = 17;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	assign pin_raw = {bus_out_i, address_out_i, command_out_i, service_out_i, data_out_i,
		operational_out_i, hold_out_i, select_out_i, suppress_out_i};

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else if (ce_i) begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
		end
	end

	bus_byte_t bo;
	logic adr_out;
	logic cmd_out;
	logic svc_out;
	logic dat_out;
	logic opl_out;
	logic hld_out;
	logic sel_out;
	logic sup_out;
	assign {bo, adr_out, cmd_out, svc_out, dat_out, opl_out, hld_out, sel_out, sup_out} = sync2_reg;

	// ------------------------------------------------------------
	// Control state
	// ------------------------------------------------------------
	port_state_t state_reg;
	logic [7:0] cmd_reg;
	logic [7:0] status_reg;
	logic retry_reg;
	logic out_tag_reg;
	logic in_tag_reg;
	logic use_data_tag_reg;
	logic [3:0] pace_reg;
	logic is_rw;
	logic is_read;
	logic xfer_offset;
	logic drop;
	logic out_tag;
	logic byte_ok;

	assign is_read = (cmd_reg[1:0] == CMD_CLASS_READ);
	assign is_rw = is_read || (cmd_reg[1:0] == CMD_CLASS_WRITE);
	assign drop = !opl_out || (!sel_out && !hld_out);
	assign out_tag = svc_out || dat_out;
	// Streaming falls back to interlock for non read/write commands
	assign xfer_offset = is_rw && (mode_i == MODE_OFFSET_INTERLOCK || mode_i == MODE_STREAMING);

	// Write FIFO between channel and drive
	logic wf_in_valid;
	logic wf_in_ready;
	chan_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.in_valid_i(wf_in_valid),
		.in_ready_o(wf_in_ready),
		.in_data_i(bo.data),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o(wr_data_o)
	);

	// A byte is offered when in-tag is down and, for DC interlock and service-only, the out-tag too
	// Nothing offered once the drive is done, else a tag rises as the data phase closes
	assign byte_ok = !in_tag_reg && (xfer_offset || !out_tag) && (pace_reg == PACE_RESET)
		&& !drive_done_i && (is_read ? rd_valid_i : wf_in_ready);
	assign rd_ready_o = (state_reg == ST_DATA) && is_read && byte_ok && !drop;
	assign wf_in_valid = (state_reg == ST_DATA) && !is_read && in_tag_reg && out_tag
		&& !out_tag_reg;

	// ------------------------------------------------------------
	// Sequence machine
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_reg <= ST_IDLE;
			cmd_reg <= 8'h00;
			status_reg <= STATUS_INIT;
			retry_reg <= 1'b0;
			drive_cmd_valid_o <= 1'b0;
		end else if (ce_i) begin
			drive_cmd_valid_o <= 1'b0;
			if (drop && state_reg != ST_IDLE) begin
				state_reg <= ST_IDLE;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						if (sel_out && adr_out && opl_out && bo.data == UNIT_ADDR && !sup_out) begin
							state_reg <= ST_ADDR;
						end
					end
					ST_ADDR: begin
						if (cmd_out) begin
							cmd_reg <= bo.data;
							drive_cmd_valid_o <= 1'b1;
							retry_reg <= retry_req_i;
							status_reg <= retry_req_i ? STATUS_RETRY : STATUS_INIT;
							state_reg <= ST_CMD;
						end
					end
					ST_CMD: begin
						if (!cmd_out) begin
							state_reg <= ST_INIT_STATUS;
						end
					end
					ST_INIT_STATUS: begin
						if (svc_out && in_tag_reg) begin
							// Control commands are complete here, so the next status ends them
							status_reg <= (retry_reg || is_rw) ? STATUS_INIT : STATUS_CE_DE;
							retry_reg <= 1'b0;
							state_reg <= retry_reg ? ST_DISC : (is_rw ? ST_DATA : ST_END_STATUS);
						end
					end
					ST_DATA: begin
						if (drive_done_i && !in_tag_reg && !out_tag) begin
							status_reg <= STATUS_CE_DE;
							state_reg <= ST_END_STATUS;
						end
					end
					ST_END_STATUS: begin
						if (svc_out && in_tag_reg) begin
							status_reg <= STATUS_INIT;
							state_reg <= ST_DISC;
						end
					end
					ST_DISC: begin
						if (!in_tag_reg && !out_tag) begin
							state_reg <= ST_IDLE;
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Tag handshake
	// ------------------------------------------------------------
	logic status_phase;
	assign status_phase = (state_reg == ST_INIT_STATUS) || (state_reg == ST_END_STATUS);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			in_tag_reg <= 1'b0;
			out_tag_reg <= 1'b0;
			use_data_tag_reg <= 1'b0;
			pace_reg <= PACE_RESET;
			bus_in_o <= '0;
		end else if (ce_i) begin
			out_tag_reg <= out_tag;
			if (pace_reg != PACE_RESET) begin
				pace_reg <= pace_reg - 1'b1;
			end
			if (drop) begin
				in_tag_reg <= 1'b0;
			end else if (in_tag_reg && out_tag && !out_tag_reg) begin
				in_tag_reg <= 1'b0;
			end else if (state_reg == ST_ADDR && in_tag_reg && cmd_out) begin
				// Command Out answers Address In; holding the tag would stall the command phase
				in_tag_reg <= 1'b0;
			end else if (status_phase && !in_tag_reg && !out_tag) begin
				in_tag_reg <= 1'b1;
				bus_in_o <= '{par: ~^status_reg, data: status_reg};
			end else if (state_reg == ST_ADDR && !in_tag_reg && !out_tag) begin
				in_tag_reg <= 1'b1;
				bus_in_o <= '{par: ~^UNIT_ADDR, data: UNIT_ADDR};
			end else if (state_reg == ST_DATA && byte_ok) begin
				in_tag_reg <= 1'b1;
				// Alternate tag pair, except in service-only mode
				use_data_tag_reg <= (mode_i != MODE_SERVICE_ONLY) && !use_data_tag_reg;
				if (mode_i == MODE_STREAMING && is_rw && !accel_i) begin
					pace_reg <= 4'(PACE_CYCLES);
				end
				if (is_read) begin
					bus_in_o <= '{par: ~^rd_data_i, data: rd_data_i};
				end
			end
		end
	end

	assign address_in_o = in_tag_reg && (state_reg == ST_ADDR || state_reg == ST_CMD);
	assign status_in_o = in_tag_reg && status_phase;
	assign service_in_o = in_tag_reg && state_reg == ST_DATA && !use_data_tag_reg;
	assign data_in_o = in_tag_reg && state_reg == ST_DATA && use_data_tag_reg;
	assign disconnect_in_o = 1'b0;
	assign operational_in_o = (state_reg != ST_IDLE);
	assign select_in_o = sel_out && (state_reg == ST_IDLE) && !(adr_out && bo.data == UNIT_ADDR);
	assign request_in_o = 1'b0;
	assign mark0_in_o = status_in_o && retry_reg;
	assign drive_cmd_o = cmd_reg;

	// Parity check on the command byte and on written Bus Out bytes
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			parity_err_o <= 1'b0;
		end else if (ce_i) begin
			if ((cmd_out && state_reg == ST_ADDR) || wf_in_valid) begin
				parity_err_o <= (^{bo.par, bo.data}) == 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_mark_status;
		@(posedge mclk_i) disable iff (reset_i) mark0_in_o |-> status_in_o && bus_in_o.data == STATUS_RETRY;
	endproperty
	a_mark_status: assert property (p_mark_status) else $error("mark without status");

	property p_bus_parity;
		@(posedge mclk_i) disable iff (reset_i) (status_in_o || service_in_o) |-> ^{bus_in_o.par, bus_in_o.data};
	endproperty
	a_bus_parity: assert property (p_bus_parity) else $error("bus in parity even");

	property p_svc_only;
		@(posedge mclk_i) disable iff (reset_i) (mode_i == MODE_SERVICE_ONLY && $rose(in_tag_reg)) |-> !data_in_o;
	endproperty
	a_svc_only: assert property (p_svc_only) else $error("data in in service-only mode");

	property p_drop;
		@(posedge mclk_i) disable iff (reset_i) (ce_i && drop) |=> state_reg == ST_IDLE && !in_tag_reg;
	endproperty
	a_drop: assert property (p_drop) else $error("still connected after drop");

	property p_tag_fall;
		@(posedge mclk_i) disable iff (reset_i) (ce_i && in_tag_reg && out_tag && !out_tag_reg) |=> !in_tag_reg;
	endproperty
	a_tag_fall: assert property (p_tag_fall) else $error("in tag held after out tag");

	property p_status_clear;
		@(posedge mclk_i) disable iff (reset_i) (ce_i && state_reg == ST_END_STATUS && svc_out && in_tag_reg && !drop)
			|=> status_reg == STATUS_INIT && state_reg == ST_DISC;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not cleared");

	property p_cmd_issue;
		@(posedge mclk_i) disable iff (reset_i) (ce_i && state_reg == ST_ADDR && cmd_out && !drop)
			|=> drive_cmd_valid_o && drive_cmd_o == $past(bo.data);
	endproperty
	a_cmd_issue: assert property (p_cmd_issue) else $error("command not issued");

	property p_pace;
		@(posedge mclk_i) disable iff (reset_i) (pace_reg != PACE_RESET) |-> !rd_ready_o;
	endproperty
	a_pace: assert property (p_pace) else $error("byte during pacing");

	property p_select_pass;
		@(posedge mclk_i) disable iff (reset_i) (state_reg != ST_IDLE) |-> !select_in_o;
	endproperty
	a_select_pass: assert property (p_select_pass) else $error("select passed while connected");

	property p_addr_fall;
		@(posedge mclk_i) disable iff (reset_i)
			(ce_i && state_reg == ST_ADDR && in_tag_reg && cmd_out && !drop) |=> !address_in_o;
	endproperty
	a_addr_fall: assert property (p_addr_fall) else $error("address in held after command");

	property p_status_fresh;
		@(posedge mclk_i) disable iff (reset_i) $rose(status_in_o) |-> $rose(in_tag_reg);
	endproperty
	a_status_fresh: assert property (p_status_fresh) else $error("status in without fresh tag");

	property p_data_rw;
		@(posedge mclk_i) disable iff (reset_i) (state_reg == ST_DATA) |-> is_rw;
	endproperty
	a_data_rw: assert property (p_data_rw) else $error("data phase for control command");

	c_select: cover property (@(posedge mclk_i) disable iff (reset_i) state_reg == ST_ADDR);
	c_retry: cover property (@(posedge mclk_i) disable iff (reset_i) mark0_in_o);
	c_data: cover property (@(posedge mclk_i) disable iff (reset_i) service_in_o ##[1:40] data_in_o);
	c_end: cover property (@(posedge mclk_i) disable iff (reset_i) state_reg == ST_DISC);
endmodule // channel_transfer_mode_port

// *** chan_port_pkg.sv ***
package chan_port_pkg;
	// ------------------------------------------------------------
	// Transfer modes and states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DC_INTERLOCK = 2'h0,
		MODE_OFFSET_INTERLOCK = 2'h1,
		MODE_SERVICE_ONLY = 2'h2,
		MODE_STREAMING = 2'h3
	} xfer_mode_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_CMD = 7'h04,
		ST_INIT_STATUS = 7'h08,
		ST_DATA = 7'h10,
		ST_END_STATUS = 7'h20,
		ST_DISC = 7'h40
	} port_state_t;

	// ------------------------------------------------------------
	// Bus byte with parity
	// ------------------------------------------------------------
	typedef struct packed {
		logic par;
		logic [7:0] data;
	} bus_byte_t;

	// Command codes: low two bits select the operation class
	localparam logic [1:0] CMD_CLASS_WRITE = 2'h1;
	localparam logic [1:0] CMD_CLASS_READ = 2'h2;
	localparam logic [7:0] STATUS_CE_DE = 8'h0C;
	localparam logic [7:0] STATUS_RETRY = 8'h02;
	localparam logic [7:0] STATUS_INIT = 8'h00;
	localparam logic [7:0] DEV_ADDR_RESET = 8'h00;
	localparam int FIFO_DEPTH = 4;
	// Tape device rate pacing in cycles between streamed bytes
	localparam int PACE_CYCLES = 8;
	localparam logic [3:0] PACE_RESET = 4'h0;
endpackage

// *** chan_fifo.sv ***
`timescale 1ns/1ps
module chan_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o = mem_reg[rd_reg];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge mclk_i) begin
		if (ce_i && push) begin
			mem_reg[wr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else if (ce_i) begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule // chan_fifo

// *** chan_model.sv ***
`timescale 1ns/1ps
// ----
// Channel side model
// ----
module chan_model
	import chan_port_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic go_i,
	input wire logic bad_par_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] cmd_i,
	input wire chan_port_pkg::bus_byte_t bus_in_i,
	input wire logic address_in_i,
	input wire logic status_in_i,
	input wire logic service_in_i,
	input wire logic data_in_i,
	input wire logic operational_in_i,
	input wire logic select_in_i,
	input wire logic mark0_in_i,
	output chan_port_pkg::bus_byte_t bus_out_o,
	output logic address_out_o,
	output logic command_out_o,
	output logic service_out_o,
	output logic data_out_o,
	output logic select_out_o,
	output logic [7:0] stat_o,
	output logic [3:0] nstat_o,
	output logic mark_o,
	output logic [7:0] nrd_o,
	output logic [7:0] last_o,
	output logic pbad_o
);
	logic [4:0] prv_reg;
	logic [7:0] nwr_reg;
	logic rs;
	logic rb;
	logic wr;
	function automatic bus_byte_t mk(input logic [7:0] d, input logic f);
		mk = {~(^d) ^ f, d};
	endfunction
	assign rs = status_in_i && !prv_reg[3];
	assign rb = !status_in_i && ((service_in_i && !prv_reg[2]) || (data_in_i && !prv_reg[1]));
	assign wr = cmd_i[1:0] == CMD_CLASS_WRITE;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			prv_reg <= 5'h00;
			bus_out_o <= 9'h000;
			address_out_o <= 1'b0;
			command_out_o <= 1'b0;
			service_out_o <= 1'b0;
			data_out_o <= 1'b0;
			select_out_o <= 1'b0;
		end else begin
			prv_reg <= {operational_in_i, status_in_i, service_in_i, data_in_i, address_in_i};
			// Released bus shows the inverse, except when Data Out falls, which leaves the last byte
			if (address_out_o && operational_in_i && !prv_reg[4]) begin
				address_out_o <= 1'b0;
				bus_out_o <= ~bus_out_o;
			end
			if (address_in_i && !prv_reg[0]) begin
				command_out_o <= 1'b1;
				bus_out_o <= mk(cmd_i, 1'b0);
			end
			if (command_out_o && !address_in_i) begin
				command_out_o <= 1'b0;
				bus_out_o <= ~bus_out_o;
			end
			if (service_out_o && !service_in_i && !status_in_i) begin
				service_out_o <= 1'b0;
				bus_out_o <= ~bus_out_o;
			end
			if (data_out_o && !data_in_i) begin
				data_out_o <= 1'b0;
			end
			if (rs) begin
				service_out_o <= 1'b1;
				stat_o <= bus_in_i.data;
				nstat_o <= nstat_o + 4'h1;
				mark_o <= mark0_in_i;
				if (^bus_in_i !== 1'b1) pbad_o <= 1'b1;
			end
			if (rb) begin
				if (data_in_i && !prv_reg[1]) data_out_o <= 1'b1;
				else service_out_o <= 1'b1;
				if (wr) begin
					bus_out_o <= mk(8'h80 + nwr_reg, bad_par_i);
					nwr_reg <= nwr_reg + 8'h01;
				end else begin
					last_o <= bus_in_i.data;
					nrd_o <= nrd_o + 8'h01;
					if (^bus_in_i !== 1'b1) pbad_o <= 1'b1;
				end
			end
			if (select_out_o && ((prv_reg[4] && !operational_in_i) || select_in_i)) begin
				select_out_o <= 1'b0;
			end
			if (go_i) begin
				select_out_o <= 1'b1;
				address_out_o <= 1'b1;
				bus_out_o <= mk(addr_i, 1'b0);
				nstat_o <= 4'h0;
				nrd_o <= 8'h00;
				nwr_reg <= 8'h00;
				mark_o <= 1'b0;
				pbad_o <= 1'b0;
			end
		end
	end
endmodule // chan_model

// *** channel_transfer_mode_port_tb.sv ***
`timescale 1ns/1ps
module channel_transfer_mode_port_tb;
	import chan_port_pkg::*;
	localparam logic [7:0] UA = 8'h00;
	localparam int LIMIT = 30000;
	logic mclk_i, reset_i, go, bad_par, opseen, retry, accel;
	logic rd_valid, wr_ready, drive_done, dcv, rd_ready, wr_valid, perr, mark, pbad;
	logic ao, co, so, doo, selo, ai, si, svi, di, opi, seli, mk0, br;
	logic [2:0] pt;
	logic [3:0] nstat;
	logic [7:0] addr, cmd, rd_data, wexp, na, nd, mgap, g, dcmd, drive_cmd, wr_data;
	logic [7:0] stat, nrd, last;
	int n_errors, cmp_count, cyc, remain, nreq, stall, nxt;
	xfer_mode_t mode;
	bus_byte_t bus_out, bus_in;
	channel_transfer_mode_port #(.UNIT_ADDR(UA)) u_channel_transfer_mode_port (
		.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1), .mode_i(mode), .accel_i(accel),
		.bus_out_i(bus_out), .address_out_i(ao), .command_out_i(co), .service_out_i(so),
		.data_out_i(doo), .operational_out_i(1'b1), .hold_out_i(selo), .select_out_i(selo),
		.suppress_out_i(1'b0), .bus_in_o(bus_in), .address_in_o(ai), .status_in_o(si),
		.service_in_o(svi), .data_in_o(di), .disconnect_in_o(), .operational_in_o(opi),
		.select_in_o(seli), .request_in_o(), .mark0_in_o(mk0), .retry_req_i(retry),
		.drive_cmd_o(drive_cmd), .drive_cmd_valid_o(dcv), .drive_done_i(drive_done),
		.rd_valid_i(rd_valid), .rd_ready_o(rd_ready), .rd_data_i(rd_data),
		.wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_data_o(wr_data), .parity_err_o(perr));
	chan_model u_chan_model (
		.mclk_i(mclk_i), .reset_i(reset_i), .go_i(go), .bad_par_i(bad_par), .addr_i(addr),
		.cmd_i(cmd), .bus_in_i(bus_in), .address_in_i(ai), .status_in_i(si),
		.service_in_i(svi), .data_in_i(di), .operational_in_i(opi), .select_in_i(seli),
		.mark0_in_i(mk0), .bus_out_o(bus_out), .address_out_o(ao), .command_out_o(co),
		.service_out_o(so), .data_out_o(doo), .select_out_o(selo), .stat_o(stat),
		.nstat_o(nstat), .mark_o(mark), .nrd_o(nrd), .last_o(last), .pbad_o(pbad));
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic give_verdict;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// Monitor and drive side
	// ----
	assign br = !si && ((svi && !pt[1]) || (di && !pt[0]));
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc >= LIMIT) begin
			n_errors++;
			give_verdict;
		end
		pt <= {ai, svi, di};
		if (dcv) dcmd <= drive_cmd;
		if (mk0 === 1'b1) chk("mark0_st", 8'h01, {7'h0, si});
		if (go) begin
			opseen <= 1'b0;
			na <= 8'h00;
			nd <= 8'h00;
			mgap <= 8'hff;
			g <= 8'h00;
		end else begin
			opseen <= opseen | opi;
			g <= (g == 8'hff) ? g : g + 8'h01;
			if (ai && !pt[2]) na <= na + 8'h01;
			if (di && !pt[0]) nd <= nd + 8'h01;
			if (br) begin
				if (g < mgap) mgap <= g;
				g <= 8'h00;
			end
		end
	end
	// Drive side answers in counted bytes, then signals done
	always @(posedge mclk_i) begin
		if (go) begin
			remain <= nreq;
			rd_data <= 8'h40;
			wexp <= 8'h80;
			rd_valid <= 1'b0;
			drive_done <= 1'b0;
		end else begin
			nxt = remain - int'(rd_valid && rd_ready) - int'(wr_valid && wr_ready);
			if (rd_valid && rd_ready) rd_data <= rd_data + 8'h01;
			if (wr_valid && wr_ready) begin
				chk("wr_data", wexp, wr_data);
				wexp <= wexp + 8'h01;
			end
			remain <= nxt;
			rd_valid <= (cmd[1:0] == CMD_CLASS_READ) && nxt > 0;
			drive_done <= nxt <= 0;
		end
		wr_ready <= cyc >= stall;
	end
	task automatic op(input xfer_mode_t m, input logic [7:0] c, input logic [7:0] a,
		input int n, input logic r, input logic bp);
		int k;
		mode <= m;
		cmd <= c;
		addr <= a;
		retry <= r;
		bad_par <= bp;
		nreq = n;
		stall = cyc + 40;
		@(posedge mclk_i) go <= 1'b1;
		@(posedge mclk_i) go <= 1'b0;
		@(posedge mclk_i);
		k = 0;
		while (k < 3000 && !(opseen && !opi) && !(seli && a != UA)) begin
			@(posedge mclk_i);
			k++;
		end
		chk("done", 8'h01, {7'h0, k < 3000});
		repeat (6) @(posedge mclk_i);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_modes;
		for (int i = 0; i < 4; i++) begin
			op(xfer_mode_t'(i), 8'h02, UA, 5, 1'b0, 1'b0);
			chk("rd_count", 8'h05, nrd);
			chk("rd_last", 8'h44, last);
			chk("end_stat", STATUS_CE_DE, stat);
			chk("n_stat", 8'h02, {4'h0, nstat});
			chk("in_par", 8'h00, {7'h0, pbad});
			chk("drv_cmd", 8'h02, dcmd);
			if (i == 2) chk("data_in", 8'h00, nd);
			if (i == 3) chk("pace", 8'h01, {7'h0, mgap >= PACE_CYCLES});
		end
	endtask
	task automatic t_write;
		op(MODE_DC_INTERLOCK, 8'h01, UA, 6, 1'b0, 1'b0);
		chk("wr_left", 8'h00, remain[7:0]);
		chk("par_ok", 8'h00, {7'h0, perr});
		chk("wr_stat", STATUS_CE_DE, stat);
	endtask
	task automatic t_parity;
		op(MODE_OFFSET_INTERLOCK, 8'h01, UA, 2, 1'b0, 1'b1);
		chk("par_err", 8'h01, {7'h0, perr});
	endtask
	task automatic t_ctrl;
		op(MODE_STREAMING, 8'h03, UA, 0, 1'b0, 1'b0);
		chk("ctl_stat", STATUS_CE_DE, stat);
		chk("ctl_data", 8'h00, nrd);
		chk("ctl_cmd", 8'h03, dcmd);
	endtask
	task automatic t_retry;
		op(MODE_DC_INTERLOCK, 8'h02, UA, 0, 1'b1, 1'b0);
		chk("rty_stat", STATUS_RETRY, stat);
		chk("rty_mark", 8'h01, {7'h0, mark});
		chk("rty_data", 8'h00, nrd);
	endtask
	task automatic t_accel;
		accel <= 1'b1;
		op(MODE_STREAMING, 8'h02, UA, 5, 1'b0, 1'b0);
		accel <= 1'b0;
		chk("acc_count", 8'h05, nrd);
		chk("acc_fast", 8'h01, {7'h0, mgap < PACE_CYCLES});
	endtask
	task automatic t_badaddr;
		op(MODE_DC_INTERLOCK, 8'h02, 8'h05, 0, 1'b0, 1'b0);
		chk("bad_adr", 8'h00, na);
	endtask
	initial begin
		reset_i = 1'b1;
		go = 1'b0;
		bad_par = 1'b0;
		retry = 1'b0;
		accel = 1'b0;
		mode = MODE_DC_INTERLOCK;
		addr = 8'h00;
		cmd = 8'h00;
		rd_valid = 1'b0;
		rd_data = 8'h00;
		wr_ready = 1'b1;
		drive_done = 1'b0;
		cyc = 0;
		remain = 0;
		stall = 0;
		n_errors = 0;
		cmp_count = 0;
		repeat (5) @(posedge mclk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		chk("rst_out", 8'h00, bus_in.data | {5'h0, opi, ai, si});
		t_modes;
		t_write;
		t_parity;
		t_ctrl;
		t_retry;
		t_accel;
		t_badaddr;
		give_verdict;
	end
endmodule // channel_transfer_mode_port_tb
